// ---- inc/flash_ctrl_defines.svh ----
// offsets, field positions, unlock keys and timing counts
`ifndef FLASH_CTRL_DEFINES_SVH
`define FLASH_CTRL_DEFINES_SVH
`define OFS_CONTROL 4'h0
`define OFS_UNLOCK 4'h1
`define OFS_LATCH 4'h2
`define OFS_PTR_LOW 4'h3
`define OFS_PTR_HIGH 4'h4
`define OFS_PTR_UPPER 4'h5
`define OFS_EE_DATA 4'h6
`define OFS_EE_ADDR 4'h7
`define OFS_TABLE_OP 4'h8
`define OFS_STATUS 4'h9
`define BIT_PGM_SEL 7
`define BIT_CFG_SEL 6
`define BIT_ROW_ERASE 4
`define BIT_WR_ERROR 3
`define BIT_WR_ENABLE 2
`define BIT_WR_START 1
`define BIT_RD_START 0
`define BIT_DONE_FLAG 0
`define BIT_BUSY 1
`define UNLOCK_FIRST 8'h55
`define UNLOCK_SECOND 8'hAA
`define PROG_TIME_US 2000
`define CLOCK_MHZ 40
`define PROG_CYCLES (`PROG_TIME_US * `CLOCK_MHZ)
`endif

// ---- inc/flash_ctrl_pkg.sv ----
// types shared by the table access controller
package flash_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PROG = 2'b01,
        ST_DONE = 2'b11
    } seq_state_e;
    typedef enum logic [1:0] {
        UNLOCK_NONE = 2'b00,
        UNLOCK_HALF = 2'b01,
        UNLOCK_OPEN = 2'b11
    } unlock_state_e;
endpackage : flash_ctrl_pkg

// ---- design/holding_bank.sv ----
// eight byte holding registers filled by table writes
`timescale 1ns/1ps
`default_nettype none
module holding_bank #(
    parameter int DEPTH = 8
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic write_i,
    input wire logic [$clog2(DEPTH)-1:0] index_i,
    input wire logic [7:0] data_i,
    output logic [DEPTH*8-1:0] block_o
);
    // the index needs at least one bit
    if (DEPTH < 2) begin : g_bad_depth
        $error("unsupported holding depth");
    end
    logic [7:0] mem_reg [DEPTH];
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= 8'h00;
            end
        end else if (write_i) begin
            mem_reg[index_i] <= data_i;
        end
    end
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            block_o[i*8 +: 8] = mem_reg[i];
        end
    end
endmodule : holding_bank
`default_nettype wire

// ---- design/program_flash_table_access_ctrl.sv ----
// table read/write and self-timed program flash sequencer
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_defines.svh"
module program_flash_table_access_ctrl
    import flash_ctrl_pkg::*;
#(
    parameter int PROG_CYCLES = `PROG_CYCLES,
    parameter int PTR_WIDTH = 22,
    parameter int EE_ADDR_WIDTH = 8
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [15:0] fetch_word_i,
    input wire logic fetch_word_valid_i,
    output logic [15:0] fetch_insn_o,
    output logic fetch_stall_o,
    output logic [PTR_WIDTH-1:0] mem_addr_o,
    input wire logic [7:0] mem_rdata_i,
    output logic [63:0] prog_block_o,
    output logic prog_write_o,
    output logic prog_erase_o,
    output logic [1:0] prog_target_o,
    output logic [EE_ADDR_WIDTH-1:0] ee_addr_o,
    output logic [7:0] ee_wdata_o,
    input wire logic [7:0] ee_rdata_i,
    output logic ee_read_o,
    output logic busy_o
);
    // pointer bytes need 17 to 24 bits; the timer needs two counts
    if (PROG_CYCLES < 2 || PTR_WIDTH < 17 || PTR_WIDTH > 24 ||
        EE_ADDR_WIDTH < 1 || EE_ADDR_WIDTH > 8) begin : g_bad_param
        $error("unsupported parameter value");
    end
    localparam int CW = $clog2(PROG_CYCLES + 1);
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] latch;
        logic [PTR_WIDTH-1:0] pointer;
        logic [7:0] ee_data;
        logic [EE_ADDR_WIDTH-1:0] ee_addr;
        logic done_flag;
        unlock_state_e unlock;
        seq_state_e seq;
        logic [CW-1:0] timer;
        logic rd_pending;
        logic tbl_read_pending;
        logic [31:0] rdata;
        logic ack;
        logic [PTR_WIDTH-1:0] op_addr;
        logic op_erase;
    } state_s;
    state_s state_reg;
    state_s state_next;
    logic [7:0] sticky_error_reg;
    logic hold_write;
    logic [63:0] hold_block;
    logic access;
    logic [7:0] wbyte;
    assign access = (avs_read_i || avs_write_i) && !state_reg.ack;
    assign wbyte = avs_writedata_i[7:0];
    holding_bank #(
        .DEPTH(8)
    ) u_hold (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .write_i(hold_write),
        .index_i(state_reg.pointer[2:0]),
        .data_i(state_reg.latch),
        .block_o(hold_block)
    );
    ////////////////////////////////////////////////////////////////////
    // error flag and selects survive reset; reset only ever sets the error flag
    // reset during programming
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            if (state_reg.seq == ST_PROG) begin
                sticky_error_reg[`BIT_WR_ERROR] <= 1'b1;
            end
        end else begin
            // only bits 7, 6 and 3 are ever read back
            sticky_error_reg <= state_next.control & 8'hC8;
        end
    end
    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [7:0] ctl;
        logic start_ok;
        ctl = 8'h00;
        start_ok = 1'b0;
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.rd_pending = 1'b0;
        state_next.tbl_read_pending = 1'b0;
        hold_write = 1'b0;
        // selects and error held outside the reset domain
        state_next.control[`BIT_PGM_SEL] = sticky_error_reg[`BIT_PGM_SEL];
        state_next.control[`BIT_CFG_SEL] = sticky_error_reg[`BIT_CFG_SEL];
        state_next.control[`BIT_WR_ERROR] = sticky_error_reg[`BIT_WR_ERROR];
        // table read lands in the latch
        if (state_reg.tbl_read_pending) begin
            state_next.latch = mem_rdata_i;
        end
        if (state_reg.rd_pending) begin
            state_next.ee_data = ee_rdata_i;
            state_next.control[`BIT_RD_START] = 1'b0;
        end
        case (state_reg.seq)
            ST_IDLE: begin
            end
            ST_PROG: begin
                if (state_reg.timer == '0) begin
                    state_next.seq = ST_DONE;
                end else begin
                    state_next.timer = state_reg.timer - 1'b1;
                end
            end
            ST_DONE: begin
                state_next.control[`BIT_WR_START] = 1'b0;
                state_next.control[`BIT_ROW_ERASE] = 1'b0;
                state_next.control[`BIT_WR_ERROR] = 1'b0;
                state_next.done_flag = 1'b1;
                state_next.seq = ST_IDLE;
            end
            default: begin
                state_next.seq = ST_IDLE;
            end
        endcase
        if (access) begin
            state_next.ack = 1'b1;
            state_next.rdata = 32'h0000_0000;
            if (avs_address_i == `OFS_CONTROL) begin
                if (avs_write_i) begin
                    ctl = wbyte;
                    state_next.control[`BIT_PGM_SEL] = ctl[`BIT_PGM_SEL];
                    state_next.control[`BIT_CFG_SEL] = ctl[`BIT_CFG_SEL];
                    state_next.control[`BIT_WR_ERROR] = ctl[`BIT_WR_ERROR];
                    // enable always latched; erase mode only latched while idle
                    state_next.control[`BIT_WR_ENABLE] = ctl[`BIT_WR_ENABLE];
                    if (state_reg.seq == ST_IDLE) begin
                        state_next.control[`BIT_ROW_ERASE] =
                            ctl[`BIT_ROW_ERASE];
                    end
                    start_ok = ctl[`BIT_WR_START] &&
                        state_reg.control[`BIT_WR_ENABLE] &&
                        state_reg.unlock == UNLOCK_OPEN &&
                        state_reg.seq == ST_IDLE;
                    if (start_ok) begin
                        state_next.control[`BIT_WR_START] = 1'b1;
                        state_next.seq = ST_PROG;
                        state_next.timer = CW'(PROG_CYCLES - 1);
                        state_next.op_erase = ctl[`BIT_ROW_ERASE];
                        if (ctl[`BIT_ROW_ERASE]) begin
                            state_next.op_addr = {state_reg.pointer[
                                PTR_WIDTH-1:6], 6'b00_0000};
                        end else begin
                            state_next.op_addr = {state_reg.pointer[
                                PTR_WIDTH-1:3], 3'b000};
                        end
                    end
                    // read start refused for program or config flash selects
                    if (ctl[`BIT_RD_START] && !ctl[`BIT_PGM_SEL] &&
                        !ctl[`BIT_CFG_SEL] &&
                        !state_reg.control[`BIT_RD_START]) begin
                        state_next.control[`BIT_RD_START] = 1'b1;
                        state_next.rd_pending = 1'b1;
                    end
                end
                state_next.rdata[7:0] = state_reg.control & 8'hDF;
            end else if (avs_address_i == `OFS_UNLOCK) begin
                if (avs_write_i) begin
                    if (wbyte == `UNLOCK_FIRST) begin
                        state_next.unlock = UNLOCK_HALF;
                    end else if (wbyte == `UNLOCK_SECOND &&
                        state_reg.unlock == UNLOCK_HALF) begin
                        state_next.unlock = UNLOCK_OPEN;
                    end else begin
                        state_next.unlock = UNLOCK_NONE;
                    end
                end
            end else if (avs_address_i == `OFS_LATCH) begin
                if (avs_write_i) begin
                    state_next.latch = wbyte;
                end
                state_next.rdata[7:0] = state_reg.latch;
            end else if (avs_address_i == `OFS_PTR_LOW) begin
                if (avs_write_i) begin
                    state_next.pointer[7:0] = wbyte;
                end
                state_next.rdata[7:0] = state_reg.pointer[7:0];
            end else if (avs_address_i == `OFS_PTR_HIGH) begin
                if (avs_write_i) begin
                    state_next.pointer[15:8] = wbyte;
                end
                state_next.rdata[7:0] = state_reg.pointer[15:8];
            end else if (avs_address_i == `OFS_PTR_UPPER) begin
                if (avs_write_i) begin
                    state_next.pointer[PTR_WIDTH-1:16] = wbyte[PTR_WIDTH-17:0];
                end
                state_next.rdata[PTR_WIDTH-17:0] =
                    state_reg.pointer[PTR_WIDTH-1:16];
            end else if (avs_address_i == `OFS_EE_DATA) begin
                if (avs_write_i) begin
                    state_next.ee_data = wbyte;
                end
                state_next.rdata[7:0] = state_reg.ee_data;
            end else if (avs_address_i == `OFS_EE_ADDR) begin
                if (avs_write_i) begin
                    state_next.ee_addr = wbyte[EE_ADDR_WIDTH-1:0];
                end
                state_next.rdata[EE_ADDR_WIDTH-1:0] = state_reg.ee_addr;
            end else if (avs_address_i == `OFS_TABLE_OP) begin
                // byte granular; bit0 write, bit1 read, bit2 post-inc
                if (avs_write_i && state_reg.seq == ST_IDLE) begin
                    if (wbyte[1]) begin
                        state_next.tbl_read_pending = 1'b1;
                    end else if (wbyte[0]) begin
                        hold_write = 1'b1;
                    end
                    if (wbyte[2]) begin
                        state_next.pointer = state_reg.pointer + 1'b1;
                    end
                end
            end else if (avs_address_i == `OFS_STATUS) begin
                // software clears; a set in the same cycle wins
                if (avs_write_i && wbyte[`BIT_DONE_FLAG] &&
                    state_reg.seq != ST_DONE) begin
                    state_next.done_flag = 1'b0;
                end
                state_next.rdata[`BIT_DONE_FLAG] = state_reg.done_flag;
                state_next.rdata[`BIT_BUSY] = state_reg.seq != ST_IDLE;
            end
            // any other access after unlock closes it
            if (!(avs_address_i == `OFS_UNLOCK && avs_write_i) &&
                !(avs_address_i == `OFS_CONTROL && avs_write_i)) begin
                state_next.unlock = UNLOCK_NONE;
            end
            if (avs_address_i == `OFS_CONTROL && avs_write_i) begin
                state_next.unlock = UNLOCK_NONE;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
    ////////////////////////////////////////////////////////////////////
    assign avs_waitrequest_o = !state_reg.ack;
    assign avs_readdata_o = state_reg.rdata;
    assign busy_o = state_reg.seq != ST_IDLE;
    assign fetch_stall_o = busy_o;
    assign fetch_insn_o = fetch_word_valid_i ? fetch_word_i : 16'h0000;
    assign mem_addr_o = busy_o ? state_reg.op_addr : state_reg.pointer;
    assign prog_block_o = hold_block;
    assign prog_write_o = state_reg.seq == ST_PROG && !state_reg.op_erase;
    assign prog_erase_o = state_reg.seq == ST_PROG && state_reg.op_erase;
    assign prog_target_o = state_reg.control[`BIT_CFG_SEL] ? 2'b10 :
        {1'b0, state_reg.control[`BIT_PGM_SEL]};
    assign ee_addr_o = state_reg.ee_addr;
    assign ee_wdata_o = state_reg.ee_data;
    assign ee_read_o = state_reg.rd_pending;
endmodule : program_flash_table_access_ctrl
`default_nettype wire

// ---- sim/flash_ctrl_checker_props.sv ----
// port assertions for the table access controller
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_checker #(
    parameter int PROG_CYCLES = 8,
    parameter int PTR_WIDTH = 22
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [15:0] fetch_word_i,
    input wire logic fetch_word_valid_i,
    input wire logic [15:0] fetch_insn_o,
    input wire logic fetch_stall_o,
    input wire logic [PTR_WIDTH-1:0] mem_addr_o,
    input wire logic [63:0] prog_block_o,
    input wire logic prog_write_o,
    input wire logic prog_erase_o,
    input wire logic ee_read_o,
    input wire logic busy_o
);
    int busy_count;
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // counts busy cycles so the timer length can be judged at the fall
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) busy_count <= 0;
        else busy_count <= busy_o ? busy_count + 1 : 0;
    end
    ////////////////////////////////////////////////////////////////////
    chk_stall_busy: assert property (
        fetch_stall_o == busy_o) else $error("stall differs from busy");
    chk_invalid_nop: assert property (
        !fetch_word_valid_i |-> fetch_insn_o == 16'h0000)
        else $error("invalid word not a no-op");
    chk_timer_length: assert property (
        $fell(busy_o) |-> busy_count == PROG_CYCLES + 1)
        else $error("busy length wrong");
    chk_prog_in_busy: assert property (
        (prog_write_o || prog_erase_o) |-> busy_o)
        else $error("programming outside busy");
    chk_block_whole: assert property (
        prog_write_o |-> mem_addr_o[2:0] == 3'h0 && !prog_erase_o)
        else $error("write block not aligned");
    chk_row_align: assert property (
        prog_erase_o |-> mem_addr_o[5:0] == 6'h00)
        else $error("erase row not aligned");
    chk_read_pulse: assert property (
        ee_read_o |=> !ee_read_o) else $error("eeprom read too long");
    chk_block_hold: assert property (
        busy_o && $past(busy_o) |-> $stable(prog_block_o))
        else $error("holding bytes moved while busy");
    cover property ($rose(prog_write_o));
    cover property ($rose(prog_erase_o));
    cover property (ee_read_o);
endmodule : flash_ctrl_checker
bind program_flash_table_access_ctrl flash_ctrl_checker #(
    .PROG_CYCLES(PROG_CYCLES), .PTR_WIDTH(PTR_WIDTH)) i_chk (
    .clock_i(clock_i), .reset_i(reset_i), .fetch_word_i(fetch_word_i),
    .fetch_word_valid_i(fetch_word_valid_i), .fetch_insn_o(fetch_insn_o),
    .fetch_stall_o(fetch_stall_o), .mem_addr_o(mem_addr_o),
    .prog_block_o(prog_block_o), .prog_write_o(prog_write_o),
    .prog_erase_o(prog_erase_o), .ee_read_o(ee_read_o), .busy_o(busy_o));
`default_nettype wire

// ---- sim/core_mem_model.sv ----
// core fetch path and memory arrays seen by the controller
`timescale 1ns/1ps
`default_nettype none
module core_mem_model (
    input wire logic clock_i,
    input wire logic [21:0] mem_addr_i,
    input wire logic [7:0] ee_addr_i,
    input wire logic ee_read_i,
    input wire logic fetch_stall_i,
    output logic [7:0] mem_rdata_o,
    output logic [7:0] ee_rdata_o,
    output logic [15:0] fetch_word_o,
    output logic fetch_word_valid_o
);
    // byte of the array at the pointer
    assign mem_rdata_o = mem_addr_i[7:0] ^ 8'h5A;
    // data valid only in the read cycle, inverted otherwise
    assign ee_rdata_o = ee_read_i ? ee_addr_i ^ 8'hC3 : ~(ee_addr_i ^ 8'hC3);
    initial begin
        fetch_word_o = 16'h1000;
        fetch_word_valid_o = 1'b1;
    end
    // fetch stands still when stalled; every fourth word invalid
    always @(posedge clock_i) begin
        if (!fetch_stall_i) begin
            fetch_word_o <= fetch_word_o + 16'h0001;
            fetch_word_valid_o <= fetch_word_o[1:0] != 2'h2;
        end
    end
endmodule : core_mem_model
`default_nettype wire

// ---- sim/tb_program_flash_table_access_ctrl.sv ----
// self-checking bench for the table access controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_defines.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
    fail_count++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_program_flash_table_access_ctrl;
    localparam int PC = 40;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdat;
    logic wait_r, f_val, stall, pw, pe, eer, busy;
    logic [15:0] f_word, f_insn;
    logic [21:0] maddr;
    logic [7:0] mrd, erd, ewd, ead;
    logic [63:0] blk, exp_blk;
    logic [1:0] tgt;
    logic [7:0] sel [3] = '{8'h00, 8'h80, 8'hC0};
    logic [1:0] exp_tgt [3] = '{2'b00, 2'b01, 2'b10};
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    program_flash_table_access_ctrl #(.PROG_CYCLES(PC)) i_dut (
        .clock_i(clock_i), .reset_i(reset_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_r),
        .fetch_word_i(f_word), .fetch_word_valid_i(f_val),
        .fetch_insn_o(f_insn), .fetch_stall_o(stall), .mem_addr_o(maddr),
        .mem_rdata_i(mrd), .prog_block_o(blk), .prog_write_o(pw),
        .prog_erase_o(pe), .prog_target_o(tgt), .ee_addr_o(ead),
        .ee_wdata_o(ewd), .ee_rdata_i(erd), .ee_read_o(eer), .busy_o(busy));
    core_mem_model i_mem (.clock_i(clock_i), .mem_addr_i(maddr),
        .ee_addr_i(ead), .ee_read_i(eer), .fetch_stall_i(stall),
        .mem_rdata_o(mrd), .ee_rdata_o(erd), .fetch_word_o(f_word),
        .fetch_word_valid_o(f_val));
    initial forever #12.5 clock_i = ~clock_i;
    ////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    // a hung handshake would otherwise stall the run forever
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic bus(input logic [3:0] a, input logic w,
            input logic [7:0] d, output logic [7:0] q);
        @(posedge clock_i);
        adr <= a;
        wd <= {24'h00_0000, d};
        wr <= w;
        rd <= !w;
        do @(posedge clock_i); while (wait_r !== 1'b0);
        q = rdat[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic wrt(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(a, 1'b1, d, q);
    endtask : wrt
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] m,
            input logic [7:0] e);
        logic [7:0] q;
        bus(a, 1'b0, 8'h00, q);
        `CHK(q & m, e)
    endtask : chk_rd
    // unlock pair then start; enable already set by the first write
    task automatic start(input logic [7:0] c);
        wrt(`OFS_CONTROL, c);
        wrt(`OFS_UNLOCK, `UNLOCK_FIRST);
        wrt(`OFS_UNLOCK, `UNLOCK_SECOND);
        wrt(`OFS_CONTROL, c | 8'h02);
        for (int i = 0; i < 4 && busy !== 1'b1; i++) @(posedge clock_i);
    endtask : start
    task automatic wait_idle();
        while (busy !== 1'b0) @(posedge clock_i);
    endtask : wait_idle
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        chk_rd(`OFS_CONTROL, 8'h37, 8'h00);
        wrt(`OFS_UNLOCK, 8'h5A);
        chk_rd(`OFS_UNLOCK, 8'hFF, 8'h00);
        wrt(4'hF, 8'hFF);
        chk_rd(4'hF, 8'hFF, 8'h00);
        $display("reset values done");
        wrt(`OFS_PTR_UPPER, 8'h01);
        wrt(`OFS_PTR_HIGH, 8'h23);
        wrt(`OFS_PTR_LOW, 8'h4D);
        wrt(`OFS_TABLE_OP, 8'h02);
        chk_rd(`OFS_LATCH, 8'hFF, 8'h17);
        wrt(`OFS_PTR_LOW, 8'h48);
        for (int i = 0; i < 8; i++) begin
            wrt(`OFS_LATCH, 8'hA0 + 8'(i));
            wrt(`OFS_TABLE_OP, 8'h05);
            exp_blk[8*i +: 8] = 8'hA0 + 8'(i);
        end
        `CHK(blk, exp_blk)
        chk_rd(`OFS_PTR_LOW, 8'hFF, 8'h50);
        $display("table ops done");
        wrt(`OFS_CONTROL, 8'h80);
        wrt(`OFS_UNLOCK, `UNLOCK_FIRST);
        wrt(`OFS_UNLOCK, `UNLOCK_SECOND);
        wrt(`OFS_CONTROL, 8'h82);
        chk_rd(`OFS_CONTROL, 8'h03, 8'h00);
        wrt(`OFS_CONTROL, 8'h84);
        wrt(`OFS_CONTROL, 8'h86);
        chk_rd(`OFS_CONTROL, 8'h02, 8'h00);
        wrt(`OFS_CONTROL, 8'h81);
        chk_rd(`OFS_CONTROL, 8'h01, 8'h00);
        `CHK(busy, 1'b0)
        $display("refusals done");
        wrt(`OFS_PTR_LOW, 8'h4D);
        for (int t = 0; t < 3; t++) begin
            start(sel[t] | 8'h04);
            `CHK(tgt, exp_tgt[t])
            if (t == 1) begin
                `CHK(pw, 1'b1)
                `CHK(maddr, 22'h01_2348)
            end
            wrt(`OFS_CONTROL, sel[t]);
            `CHK(busy, 1'b1)
            chk_rd(`OFS_STATUS, 8'h02, 8'h02);
            chk_rd(`OFS_CONTROL, 8'h02, 8'h02);
            wait_idle();
            chk_rd(`OFS_CONTROL, 8'h02, 8'h00);
            chk_rd(`OFS_STATUS, 8'h01, 8'h01);
            wrt(`OFS_STATUS, 8'h01);
            chk_rd(`OFS_STATUS, 8'h01, 8'h00);
        end
        $display("writes done");
        start(8'h94);
        `CHK(pe, 1'b1)
        `CHK(maddr, 22'h01_2340)
        wait_idle();
        chk_rd(`OFS_CONTROL, 8'h10, 8'h00);
        $display("erase done");
        wrt(`OFS_CONTROL, 8'h00);
        wrt(`OFS_EE_ADDR, 8'h3C);
        wrt(`OFS_CONTROL, 8'h01);
        chk_rd(`OFS_EE_DATA, 8'hFF, 8'hFF);
        chk_rd(`OFS_CONTROL, 8'h01, 8'h00);
        wrt(`OFS_EE_DATA, 8'h96);
        `CHK(ewd, 8'h96)
        `CHK(ead, 8'h3C)
        $display("eeprom read done");
        start(8'h84);
        reset_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        chk_rd(`OFS_CONTROL, 8'hC8, 8'h88);
        chk_rd(`OFS_EE_ADDR, 8'hFF, 8'h00);
        chk_rd(`OFS_EE_DATA, 8'hFF, 8'h00);
        `CHK(ewd, 8'h00)
        `CHK(ead, 8'h00)
        `CHK(busy, 1'b0)
        $display("reset abort done");
        final_report();
    end
endmodule : tb_program_flash_table_access_ctrl
`default_nettype wire
